// ==== verilog/mqf_flag_logic.sv ====
// almost full / almost empty flag logic of a four-queue device
// Notes on behaviour
// - write reaching almost-full drives discrete almost-full low two cycles later.
// - write queue switch updates discrete almost-full flag after two cycles.
// - read leaving almost-full releases flag after skew plus two cycles.
// - read reaching almost-empty drives discrete almost-empty low two cycles later.
// - write leaving almost-empty releases flag after skew plus two cycles.
// - read queue switch makes almost-empty flag show the new queue.
// - device without a write queue keeps almost-full flag undriven.
// - unselected read device keeps almost-empty flag and data undriven.
// - almost-empty bus shows a newly selected device one cycle later.
// - status bus bit n carries queue n of the driving device.
// - at almost-empty bus handover old device releases as new one drives.
// - almost-full bus shows the device selected on the previous cycle.
// - device losing the almost-full bus releases its outputs.
// - read below almost-full raises bus bit after skew plus two cycles.
// - write re-entering almost-full lowers bus bit and discrete flag together.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module mqf_flag_logic
  import mqf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wr_sel_strobe,
  input wire logic wr_sel_dev,
  input wire logic [Q_W-1:0] wr_sel_queue,
  input wire logic wr_en,
  input wire logic rd_sel_strobe,
  input wire logic rd_sel_dev,
  input wire logic [Q_W-1:0] rd_sel_queue,
  input wire logic rd_en,
  input wire logic af_bus_sel_strobe,
  input wire logic af_bus_sel_dev,
  input wire logic ae_bus_sel_strobe,
  input wire logic ae_bus_sel_dev,
  input wire logic status_bus_expansion_in,
  output logic almost_full_flag_n,
  output logic almost_full_flag_oe,
  output logic almost_empty_flag_n,
  output logic almost_empty_flag_oe,
  output logic data_out_oe,
  output logic [NUM_Q-1:0] almost_full_status_bus,
  output logic almost_full_status_bus_oe,
  output logic [NUM_Q-1:0] almost_empty_status_bus,
  output logic almost_empty_status_bus_oe,
  output logic status_bus_expansion_out
);
  logic [CNT_W-1:0] af_offset_reg;
  logic [CNT_W-1:0] ae_offset_reg;
  logic [Q_W-1:0] wr_q_reg;
  logic [Q_W-1:0] rd_q_reg;
  logic wr_active_reg;
  logic rd_active_reg;
  logic af_bus_own_reg;
  logic ae_bus_own_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic strap_s3_reg;
  logic strap_done_reg;
  logic master_reg;
  logic [1:0] strap_age_reg;
  logic strap_settle;
  logic af_sel_reg;
  logic af_act_reg;
  logic ae_sel_reg;
  logic ae_act_reg;
  logic [NUM_Q-1:0] af_bus_stage_reg;
  logic [NUM_Q-1:0] ae_bus_stage_reg;
  logic [NUM_Q-1:0] wr_pulse;
  logic [NUM_Q-1:0] rd_pulse;
  logic [NUM_Q-1:0] q_af;
  logic [NUM_Q-1:0] q_ae;
  logic aw_got_reg;
  logic w_got_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_commit;
  logic [31:0] rd_word;
  logic rd_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_Q; gi++) begin : g_queue
      // events count only for the queue this device has selected
      assign wr_pulse[gi] = wr_en && wr_active_reg && (wr_q_reg == Q_W'(gi));
      assign rd_pulse[gi] = rd_en && rd_active_reg && (rd_q_reg == Q_W'(gi));
      mqf_queue_level u_level (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_pulse(wr_pulse[gi]),
        .rd_pulse(rd_pulse[gi]),
        .af_offset(af_offset_reg),
        .ae_offset(ae_offset_reg),
        .almost_full(q_af[gi]),
        .almost_empty(q_ae[gi])
      );
    end
  endgenerate

  // queue selection; a write in the select cycle still hits the old queue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q_reg <= '0;
      wr_active_reg <= 1'b0;
    end else if (wr_sel_strobe) begin
      wr_q_reg <= wr_sel_queue;
      wr_active_reg <= wr_sel_dev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q_reg <= '0;
      rd_active_reg <= 1'b0;
    end else if (rd_sel_strobe) begin
      rd_q_reg <= rd_sel_queue;
      rd_active_reg <= rd_sel_dev;
    end
  end

  // strap is a static pin: three flops, settled once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
      strap_s3_reg <= 1'b1;
      strap_age_reg <= 2'h0;
    end else begin
      strap_s1_reg <= status_bus_expansion_in;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      if (strap_age_reg != 2'h3) strap_age_reg <= strap_age_reg + 2'h1;
    end
  end
  // stage reset values agree as well, so wait until the pin has reached stage three
  assign strap_settle = !strap_done_reg && strap_age_reg == 2'h3 && strap_s2_reg == strap_s3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (strap_settle) begin
      strap_done_reg <= 1'b1;
      master_reg <= !strap_s3_reg;
    end
  end

  // bus ownership: reset releases both buses; master takes them once the strap settles, a selection strobe wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_bus_own_reg <= 1'b0;
    end else if (af_bus_sel_strobe) begin
      af_bus_own_reg <= af_bus_sel_dev;
    end else if (strap_settle) begin
      af_bus_own_reg <= !strap_s3_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ae_bus_own_reg <= 1'b0;
    end else if (ae_bus_sel_strobe) begin
      ae_bus_own_reg <= ae_bus_sel_dev;
    end else if (strap_settle) begin
      ae_bus_own_reg <= !strap_s3_reg;
    end
  end

  // flag and enable move together, two stages after a write or a queue switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_sel_reg <= 1'b0;
      af_act_reg <= 1'b0;
      almost_full_flag_n <= 1'b1;
      almost_full_flag_oe <= 1'b0;
    end else begin
      af_sel_reg <= q_af[wr_q_reg];
      af_act_reg <= wr_active_reg;
      almost_full_flag_n <= !af_sel_reg;
      almost_full_flag_oe <= af_act_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ae_sel_reg <= 1'b0;
      ae_act_reg <= 1'b0;
      almost_empty_flag_n <= 1'b1;
      almost_empty_flag_oe <= 1'b0;
      data_out_oe <= 1'b0;
    end else begin
      ae_sel_reg <= q_ae[rd_q_reg];
      ae_act_reg <= rd_active_reg;
      almost_empty_flag_n <= !ae_sel_reg;
      almost_empty_flag_oe <= ae_act_reg;
      data_out_oe <= ae_act_reg;
    end
  end

  // ownership changes on one common edge, so handover never overlaps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_bus_stage_reg <= '0;
      almost_full_status_bus <= '1;
      almost_full_status_bus_oe <= 1'b0;
    end else begin
      af_bus_stage_reg <= q_af;
      almost_full_status_bus <= ~af_bus_stage_reg;
      almost_full_status_bus_oe <= af_bus_own_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ae_bus_stage_reg <= '0;
      almost_empty_status_bus <= '1;
      almost_empty_status_bus_oe <= 1'b0;
    end else begin
      ae_bus_stage_reg <= q_ae;
      almost_empty_status_bus <= ~ae_bus_stage_reg;
      almost_empty_status_bus_oe <= ae_bus_own_reg;
    end
  end

  // expansion output is left open in direct mode; held low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_bus_expansion_out <= 1'b0;
    end else begin
      status_bus_expansion_out <= 1'b0;
    end
  end

  // axi4-lite write: address and data taken in either order
  assign wr_commit = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_got_reg <= 1'b0;
    end else if (!aw_got_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_got_reg <= 1'b0;
    end else if (!w_got_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg == AF_OFFSET_ADDR || aw_addr_reg == AE_OFFSET_ADDR) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // thresholds move the flag boundaries of every queue at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_offset_reg <= AF_OFFSET_RST;
      ae_offset_reg <= AE_OFFSET_RST;
    end else if (wr_commit) begin
      if (aw_addr_reg == AF_OFFSET_ADDR) begin
        if (w_strb_reg[0]) af_offset_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) af_offset_reg[CNT_W-1:8] <= w_data_reg[CNT_W-1:8];
      end
      if (aw_addr_reg == AE_OFFSET_ADDR) begin
        if (w_strb_reg[0]) ae_offset_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) ae_offset_reg[CNT_W-1:8] <= w_data_reg[CNT_W-1:8];
      end
    end
  end

  // axi4-lite read
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == AF_OFFSET_ADDR) begin
      rd_word[CNT_W-1:0] = af_offset_reg;
    end else if (s_axi_araddr == AE_OFFSET_ADDR) begin
      rd_word[CNT_W-1:0] = ae_offset_reg;
    end else if (s_axi_araddr == STATUS_ADDR) begin
      rd_word[STAT_AF_POS +: NUM_Q] = q_af;
      rd_word[STAT_AE_POS +: NUM_Q] = q_ae;
      rd_word[STAT_WRQ_POS +: Q_W] = wr_q_reg;
      rd_word[STAT_RDQ_POS +: Q_W] = rd_q_reg;
      rd_word[STAT_WRACT_POS] = wr_active_reg;
      rd_word[STAT_RDACT_POS] = rd_active_reg;
      rd_word[STAT_MASTER_POS] = master_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mqf_pkg.sv ====
// constants shared by the multi-queue almost flag logic
package mqf_pkg;
  localparam int NUM_Q = 4;
  localparam int Q_W = 2;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] QUEUE_DEPTH = 14'h2000;
  localparam logic [CNT_W-1:0] AF_OFFSET_RST = 14'h007f;
  localparam logic [CNT_W-1:0] AE_OFFSET_RST = 14'h007f;
  // one flop of skew between the writing and the reading view of a queue
  localparam int FLAG_SYNC_SKEW_CYC = 1;
  localparam int BUS_FLAG_SYNC_SKEW_CYC = 1;
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] AF_OFFSET_ADDR = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] AE_OFFSET_ADDR = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STAT_AF_POS = 0;
  localparam int STAT_AE_POS = 4;
  localparam int STAT_WRQ_POS = 8;
  localparam int STAT_RDQ_POS = 10;
  localparam int STAT_WRACT_POS = 12;
  localparam int STAT_RDACT_POS = 13;
  localparam int STAT_MASTER_POS = 14;
endpackage

// ==== verilog/mqf_queue_level.sv ====
// write-side and read-side fill views of one queue with their almost flags
`timescale 1ns/10ps
`default_nettype none
module mqf_queue_level
  import mqf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_pulse,
  input wire logic rd_pulse,
  input wire logic [CNT_W-1:0] af_offset,
  input wire logic [CNT_W-1:0] ae_offset,
  output logic almost_full,
  output logic almost_empty
);
  logic wr_sync_reg;
  logic rd_sync_reg;
  logic [CNT_W-1:0] wr_view_reg;
  logic [CNT_W-1:0] rd_view_reg;
  logic [CNT_W-1:0] wr_view_next;
  logic [CNT_W-1:0] rd_view_next;

  // each side sees the other side's events one stage late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_sync_reg <= 1'b0;
      rd_sync_reg <= 1'b0;
    end else begin
      // forward only events the own view accepted, so both views stay equal
      wr_sync_reg <= wr_pulse && (wr_view_reg != QUEUE_DEPTH || rd_sync_reg);
      rd_sync_reg <= rd_pulse && (rd_view_reg != 14'h0000 || wr_sync_reg);
    end
  end

  // saturating counts guard against host overruns
  always_comb begin
    wr_view_next = wr_view_reg;
    if (wr_pulse && !rd_sync_reg && wr_view_reg != QUEUE_DEPTH) begin
      wr_view_next = wr_view_reg + 14'h0001;
    end else if (!wr_pulse && rd_sync_reg && wr_view_reg != 14'h0000) begin
      wr_view_next = wr_view_reg - 14'h0001;
    end
    rd_view_next = rd_view_reg;
    if (wr_sync_reg && !rd_pulse && rd_view_reg != QUEUE_DEPTH) begin
      rd_view_next = rd_view_reg + 14'h0001;
    end else if (!wr_sync_reg && rd_pulse && rd_view_reg != 14'h0000) begin
      rd_view_next = rd_view_reg - 14'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_view_reg <= 14'h0000;
      rd_view_reg <= 14'h0000;
    end else begin
      wr_view_reg <= wr_view_next;
      rd_view_reg <= rd_view_next;
    end
  end

  assign almost_full = (wr_view_reg >= (QUEUE_DEPTH - af_offset));
  assign almost_empty = (rd_view_reg <= ae_offset);
endmodule
`default_nettype wire

// ==== testbench/mqf_host_model.sv ====
// host side model: queue and bus selects, enables, strap
`timescale 1ns/10ps
`default_nettype none
module mqf_host_model
  import mqf_pkg::*;
(
  input wire logic aclk,
  output logic wr_sel_strobe,
  output logic wr_sel_dev,
  output logic [Q_W-1:0] wr_sel_queue,
  output logic wr_en,
  output logic rd_sel_strobe,
  output logic rd_sel_dev,
  output logic [Q_W-1:0] rd_sel_queue,
  output logic rd_en,
  output logic af_bus_sel_strobe,
  output logic af_bus_sel_dev,
  output logic ae_bus_sel_strobe,
  output logic ae_bus_sel_dev,
  output logic status_bus_expansion_in
);
  logic [3:0] stb = 4'h0;
  logic [3:0] dev = 4'h0;
  logic [Q_W-1:0] wq = '0;
  logic [Q_W-1:0] rq = '0;
  logic [1:0] en = 2'h0;
  assign {ae_bus_sel_strobe, af_bus_sel_strobe, rd_sel_strobe, wr_sel_strobe} = stb;
  assign {ae_bus_sel_dev, af_bus_sel_dev, rd_sel_dev, wr_sel_dev} = dev;
  assign wr_sel_queue = wq;
  assign rd_sel_queue = rq;
  assign {rd_en, wr_en} = en;
  // strapped as master of the group, expansion output left open
  assign status_bus_expansion_in = 1'b0;
  // select lines go stale after the strobe so nothing relies on them
  task automatic sel(input int k, input logic d, input logic [Q_W-1:0] q);
    @(posedge aclk);
    stb[k] <= 1'b1;
    dev[k] <= d;
    if (k == 0) wq <= q;
    if (k == 1) rq <= q;
    @(posedge aclk);
    stb <= 4'h0;
    dev <= ~dev;
    {wq, rq} <= ~{wq, rq};
  endtask
  task automatic pulse(input logic w, input logic r);
    @(posedge aclk);
    en <= {r, w};
    @(posedge aclk);
    en <= 2'h0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/mqf_flag_logic_props.sv ====
// checker for the almost flag and status bus ports
`timescale 1ns/10ps
`default_nettype none
module mqf_flag_logic_props
  import mqf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_sel_strobe,
  input wire logic wr_sel_dev,
  input wire logic [Q_W-1:0] wr_sel_queue,
  input wire logic wr_en,
  input wire logic rd_sel_strobe,
  input wire logic rd_sel_dev,
  input wire logic rd_en,
  input wire logic af_bus_sel_strobe,
  input wire logic af_bus_sel_dev,
  input wire logic ae_bus_sel_strobe,
  input wire logic ae_bus_sel_dev,
  input wire logic almost_full_flag_n,
  input wire logic almost_full_flag_oe,
  input wire logic almost_empty_flag_n,
  input wire logic almost_empty_flag_oe,
  input wire logic data_out_oe,
  input wire logic [NUM_Q-1:0] almost_full_status_bus,
  input wire logic almost_full_status_bus_oe,
  input wire logic almost_empty_status_bus_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // age since a select: a queue switch also moves the flag
  logic [2:0] wage;
  logic [2:0] rage;
  logic [Q_W-1:0] wq;
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_sel_strobe) wage <= 3'h0;
    else if (wage != 3'h7) wage <= wage + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || rd_sel_strobe) rage <= 3'h0;
    else if (rage != 3'h7) rage <= rage + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (wr_sel_strobe) wq <= wr_sel_queue;
  end
  property p_af_off;
    wr_sel_strobe && !wr_sel_dev ##1 !wr_sel_strobe [*2] |=> !almost_full_flag_oe;
  endproperty
  a_af_off: assert property (p_af_off) else $error("flag driven, no write queue");
  property p_ae_off;
    rd_sel_strobe && !rd_sel_dev ##1 !rd_sel_strobe [*2] |=> !almost_empty_flag_oe && !data_out_oe;
  endproperty
  a_ae_off: assert property (p_ae_off) else $error("read side driven unselected");
  property p_ae_bus_on;
    ae_bus_sel_strobe && ae_bus_sel_dev ##1 !ae_bus_sel_strobe |=> almost_empty_status_bus_oe;
  endproperty
  a_ae_bus_on: assert property (p_ae_bus_on) else $error("empty bus not taken");
  property p_af_bus_off;
    af_bus_sel_strobe && !af_bus_sel_dev ##1 !af_bus_sel_strobe |=> !almost_full_status_bus_oe;
  endproperty
  a_af_bus_off: assert property (p_af_bus_off) else $error("full bus not released");
  property p_af_match;
    wage == 3'h7 && almost_full_flag_oe |-> almost_full_flag_n == almost_full_status_bus[wq];
  endproperty
  a_af_match: assert property (p_af_match) else $error("flag and bus bit differ");
  property p_af_fall;
    $fell(almost_full_flag_n) && wage == 3'h7 && almost_full_flag_oe |-> $past(wr_en, 3);
  endproperty
  a_af_fall: assert property (p_af_fall) else $error("full flag fell late or early");
  property p_af_rise;
    $rose(almost_full_flag_n) && wage == 3'h7 && almost_full_flag_oe |-> $past(rd_en, 4);
  endproperty
  a_af_rise: assert property (p_af_rise) else $error("full flag rose off time");
  property p_ae_fall;
    $fell(almost_empty_flag_n) && rage == 3'h7 && almost_empty_flag_oe |-> $past(rd_en, 3);
  endproperty
  a_ae_fall: assert property (p_ae_fall) else $error("empty flag fell off time");
  c_af_fall: cover property ($fell(almost_full_flag_n) && wage == 3'h7);
  c_af_rise: cover property ($rose(almost_full_flag_n) && wage == 3'h7);
  c_ae_bus_off: cover property ($fell(almost_empty_status_bus_oe));
endmodule
bind mqf_flag_logic mqf_flag_logic_props u_props (.*);
`default_nettype wire

// ==== testbench/mqf_flag_logic_tb_top.sv ====
// self-checking bench: flags, buses, selects, registers
`timescale 1ns/10ps
`default_nettype none
module mqf_flag_logic_tb_top
  import mqf_pkg::*;
;
  localparam int AFO = 8188;
  localparam int AEO = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, r;
  logic [3:0] s_axi_wstrb, oh;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wr_sel_strobe, wr_sel_dev, wr_en, rd_sel_strobe, rd_sel_dev, rd_en;
  logic af_bus_sel_strobe, af_bus_sel_dev, ae_bus_sel_strobe, ae_bus_sel_dev;
  logic status_bus_expansion_in, status_bus_expansion_out, data_out_oe;
  logic [Q_W-1:0] wr_sel_queue, rd_sel_queue, q;
  logic almost_full_flag_n, almost_full_flag_oe, almost_empty_flag_n, almost_empty_flag_oe;
  logic [NUM_Q-1:0] almost_full_status_bus, almost_empty_status_bus;
  logic almost_full_status_bus_oe, almost_empty_status_bus_oe;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int cnt = 0;
  mqf_flag_logic dut (.*);
  mqf_host_model host (.*);
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic af_n(input int c);
    return !(c >= 8192 - AFO);
  endfunction
  function automatic logic ae_n(input int c);
    return !(c <= AEO);
  endfunction
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // both latencies have settled after four edges
  task automatic chk_q();
    tick(4);
    chk(almost_full_flag_n, af_n(cnt));
    chk(almost_full_status_bus[q], af_n(cnt));
    chk(almost_empty_flag_n, ae_n(cnt));
    chk(almost_empty_status_bus[q], ae_n(cnt));
  endtask
  initial begin
    seed = 32'h6d51545c;
    s_axi_wstrb = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(8);
    chk(almost_full_status_bus, 4'hf);
    chk(almost_empty_status_bus, 4'h0);
    chk(almost_full_flag_oe, 1'b0);
    chk(almost_empty_status_bus_oe, 1'b1);
    chk(status_bus_expansion_out, 1'b0);
    axi_rd(AF_OFFSET_ADDR, 32'h7f, RESP_OKAY);
    axi_rd(4'hc, 32'h0, RESP_SLVERR);
    axi_wr(STATUS_ADDR, 32'h0, RESP_SLVERR);
    axi_wr(AF_OFFSET_ADDR, AFO, RESP_OKAY);
    axi_wr(AE_OFFSET_ADDR, AEO, RESP_OKAY);
    axi_rd(AE_OFFSET_ADDR, AEO, RESP_OKAY);
    q = Q_W'(xs());
    host.sel(0, 1'b1, q);
    host.sel(1, 1'b1, q);
    tick(3);
    chk(almost_full_flag_oe, 1'b1);
    chk(data_out_oe, 1'b1);
    chk_q();
    repeat (5) begin
      host.pulse(1'b1, 1'b0);
      cnt++;
      chk_q();
    end
    repeat (40) begin
      r = xs();
      // a read of an empty queue is refused; keep reads off it
      r[1] = r[1] && (cnt > 0);
      host.pulse(r[0], r[1]);
      cnt = cnt + int'(r[0]) - int'(r[1]);
      if (cnt < 0) cnt = 0;
      chk_q();
    end
    while (cnt < 4) begin
      host.pulse(1'b1, 1'b0);
      cnt++;
    end
    oh = 4'h1 << q;
    axi_rd(STATUS_ADDR, {17'h0, 3'h7, q, q, ~oh, oh}, RESP_OKAY);
    host.sel(0, 1'b1, q + 2'h1);
    host.sel(1, 1'b1, q + 2'h1);
    tick(3);
    chk(almost_full_flag_n, 1'b1);
    chk(almost_empty_flag_n, 1'b0);
    chk(almost_full_status_bus[q], 1'b0);
    host.sel(2, 1'b0, '0);
    host.sel(3, 1'b0, '0);
    tick(3);
    chk(almost_full_status_bus_oe, 1'b0);
    chk(almost_empty_status_bus_oe, 1'b0);
    host.sel(3, 1'b1, '0);
    tick(3);
    chk(almost_empty_status_bus_oe, 1'b1);
    host.sel(0, 1'b0, '0);
    host.sel(1, 1'b0, '0);
    tick(3);
    chk(almost_full_flag_oe, 1'b0);
    chk({almost_empty_flag_oe, data_out_oe}, 2'h0);
    end_sim();
  end
endmodule
`default_nettype wire
